// ===== hdl/pcell_top.sv
// Programmable pin cell with Avalon-MM configuration slave
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps

module pcell_top
  import pcell_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_core_out,
  input wire logic i_core_oe,
  input wire logic i_core_ce,
  input wire logic i_core_aclr,
  input wire logic i_local_out,
  input wire logic i_local_oe,
  output logic o_core_in,
  output logic o_core_reg,
  output logic o_fast_dist,
  input wire logic i_pin,
  output logic o_pin_out,
  output logic o_pin_oe_n
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pcell_cfg_t cfg;
  pcell_dly_t dly;
  pcell_pin_t next_pin;
  logic req;
  logic sel_cfg;
  logic sel_dly;
  logic sel_sts;
  logic [31:0] next_readdata;
  logic cell_rst_n;
  logic cell_raw;
  logic cell_q;
  logic in_core_d;
  logic in_reg_d;
  logic out_reg_d;
  logic ce_d;
  logic data_src;
  logic pin_data_d;
  logic route_out;
  logic route_oe;
  logic le_oe;
  logic le_in;
  logic oe_src;
  logic oe_eff;

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  assign req = i_read | i_write;
  assign sel_cfg = (i_address[3:2] == PCELL_OFS_CONFIG[3:2]);
  assign sel_dly = (i_address[3:2] == PCELL_OFS_DELAY[3:2]);
  assign sel_sts = (i_address[3:2] == PCELL_OFS_STATUS[3:2]);

  // One wait cycle, then a single-cycle answer
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_waitrequest <= 1'b1;
    end else if (req && o_waitrequest) begin
      o_waitrequest <= 1'b0;
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  // Read data mux, unmapped words read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (sel_cfg) begin
      next_readdata[PCELL_CFG_W-1:0] = cfg;
    end else if (sel_dly) begin
      next_readdata[PCELL_DLY_W-1:0] = dly;
    end else if (sel_sts) begin
      next_readdata[3:0] = {le_in, !o_pin_oe_n, cell_q, i_pin};
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_readdata <= 32'h0000_0000;
    end else if (i_read && o_waitrequest) begin
      o_readdata <= next_readdata;
    end
  end

  // Configuration register, byte lanes 0 and 1
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg <= PCELL_CFG_RST;
    end else if (i_write && !o_waitrequest && sel_cfg) begin
      if (i_byteenable[0]) begin
        cfg[7:0] <= i_writedata[7:0];
      end
      if (i_byteenable[1]) begin
        cfg[PCELL_CFG_W-1:8] <= i_writedata[PCELL_CFG_W-1:8];
      end
    end
  end

  // Delay selection register, byte lanes 0 and 1
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      dly <= PCELL_DLY_RST;
    end else if (i_write && !o_waitrequest && sel_dly) begin
      if (i_byteenable[0]) begin
        dly[7:0] <= i_writedata[7:0];
      end
      if (i_byteenable[1]) begin
        dly[PCELL_DLY_W-1:8] <= i_writedata[PCELL_DLY_W-1:8];
      end
    end
  end

  // ****************************************************************
  // Delay chains
  // ****************************************************************
  assign route_out = (cfg.fast_pin ? i_local_out : i_core_out) ^ cfg.inv_out;
  assign route_oe = (cfg.fast_pin ? i_local_oe : i_core_oe) ^ cfg.inv_oe;

  // Five independent delay paths
  pcell_delay u_dly_pin_core (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_sel(dly.pin_core),
    .i_data(i_pin),
    .o_data(in_core_d)
  );

  pcell_delay u_dly_pin_ireg (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_sel(dly.pin_ireg),
    .i_data(i_pin),
    .o_data(in_reg_d)
  );

  pcell_delay u_dly_core_oreg (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_sel(dly.core_oreg),
    .i_data(route_out),
    .o_data(out_reg_d)
  );

  pcell_delay u_dly_oreg_pin (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_sel(dly.oreg_pin),
    .i_data(data_src),
    .o_data(pin_data_d)
  );

  pcell_delay u_dly_clk_en (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_sel(dly.clk_en),
    .i_data(i_core_ce),
    .o_data(ce_d)
  );

  // ****************************************************************
  // Cell register
  // ****************************************************************
  // Stored relative to the start level so reset takes a constant
  assign cell_rst_n = i_resetn & ~i_core_aclr;
  assign cell_q = cell_raw ^ cfg.pu_high;

  // Captures pin data or core data by role
  always_ff @(posedge i_clock or negedge cell_rst_n) begin
    if (!cell_rst_n) begin
      cell_raw <= 1'b0;
    end else if (ce_d) begin
      if (cfg.reg_out || cfg.fast_bidir) begin
        cell_raw <= out_reg_d ^ cfg.pu_high;
      end else begin
        cell_raw <= in_reg_d ^ cfg.pu_high;
      end
    end
  end

  // Output data: registered or straight from routing
  assign data_src = (cfg.reg_out || cfg.fast_bidir) ? cell_q : out_reg_d;

  // ****************************************************************
  // Neighbouring logic element registers
  // ****************************************************************
  // Fast bidirectional OE and input capture outside the cell
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      le_oe <= 1'b0;
      le_in <= 1'b0;
    end else if (ce_d) begin
      le_oe <= route_oe;
      le_in <= in_reg_d;
    end
  end

  // ****************************************************************
  // Output enable and pin drive
  // ****************************************************************
  assign oe_src = cfg.fast_bidir ? le_oe : route_oe;

  // Enable by direction mode, gated by configuration done
  always_comb begin
    case (cfg.dir)
      PCELL_DIR_IN: oe_eff = 1'b0;
      PCELL_DIR_OUT: oe_eff = 1'b1;
      default: oe_eff = oe_src;
    endcase
    if (!cfg.cfg_done) begin
      oe_eff = 1'b0;
    end
  end

  // Next pin drive; open drain only pulls low
  always_comb begin
    next_pin.data = pin_data_d;
    next_pin.oe_n = !oe_eff;
    if (cfg.open_drain) begin
      next_pin.data = 1'b0;
      next_pin.oe_n = !(oe_eff && !pin_data_d);
    end
  end

  // Registered pin outputs
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_out <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end else begin
      o_pin_out <= next_pin.data;
      o_pin_oe_n <= next_pin.oe_n;
    end
  end

  // Input side sees the pin, driven or not, except o_core_reg when reg_out is set without fast_bidir and o_fast_dist when fast_pin is clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_core_in <= 1'b0;
      o_core_reg <= 1'b0;
      o_fast_dist <= 1'b0;
    end else begin
      o_core_in <= in_core_d;
      o_core_reg <= cfg.fast_bidir ? le_in : cell_q;
      o_fast_dist <= cfg.fast_pin ? i_pin : 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_od_never_high: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    $past(cfg.open_drain) && !o_pin_oe_n |-> !o_pin_out && !$past(pin_data_d)
  ) else $error("open drain drove a high level");

  a_unconfig_released: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    !$past(cfg.cfg_done) |-> o_pin_oe_n
  ) else $error("pin driven before configuration done");

  a_input_only_mode: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    $past(cfg.dir) == PCELL_DIR_IN |-> o_pin_oe_n
  ) else $error("input-only pin was driven");

  a_output_only_mode: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    $past(cfg.dir) == PCELL_DIR_OUT && $past(cfg.cfg_done) && !$past(cfg.open_drain)
      |-> !o_pin_oe_n
  ) else $error("output-only pin was not driven");

  a_clear_forces_low: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    i_core_aclr && !cfg.pu_high |-> !cell_q
  ) else $error("clear did not force cell register low");

  a_preset_forces_high: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    i_core_aclr && cfg.pu_high |-> cell_q
  ) else $error("preset did not force cell register high");

  a_input_capture: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    !cfg.reg_out && !cfg.fast_bidir && ce_d && !i_core_aclr ##1 !i_core_aclr && $stable(cfg)
      |-> cell_q == $past(in_reg_d)
  ) else $error("cell register missed pin capture");

  a_disabled_releases: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    $past(cfg.dir) == PCELL_DIR_BIDIR && !$past(oe_src) |-> o_pin_oe_n
  ) else $error("disabled bidirectional pin still driven");

  a_core_sees_pin: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    $past(i_resetn) && $past(dly.pin_core) == PCELL_DLY_OFF |-> o_core_in == $past(i_pin)
  ) else $error("pin level lost on input path");

  a_bus_answer: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    req && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest
  ) else $error("bus answer not a single cycle after one wait");

endmodule

// ===== hdl/pcell_pkg.sv
// Package with register map, field layouts and types of the programmable pin cell
package pcell_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [3:0] PCELL_OFS_CONFIG = 4'h0;
  localparam logic [3:0] PCELL_OFS_DELAY = 4'h4;
  localparam logic [3:0] PCELL_OFS_STATUS = 4'h8;

  // ****************************************************************
  // Reset values and widths
  // ****************************************************************
  localparam int PCELL_CFG_W = 10;
  localparam int PCELL_DLY_W = 10;
  localparam logic [PCELL_CFG_W-1:0] PCELL_CFG_RST = 10'h000;
  localparam logic [PCELL_DLY_W-1:0] PCELL_DLY_RST = 10'h000;
  localparam int PCELL_DLY_STAGES = 3;
  localparam logic [1:0] PCELL_DLY_OFF = 2'h0;

  // Pin direction modes
  typedef enum logic [1:0] {
    PCELL_DIR_IN = 2'h0,
    PCELL_DIR_OUT = 2'h1,
    PCELL_DIR_BIDIR = 2'h2,
    PCELL_DIR_BIDIR_ALT = 2'h3
  } pcell_dir_t;

  // Configuration word, bit 0 is dir[0]
  typedef struct packed {
    logic cfg_done;
    logic fast_pin;
    logic fast_bidir;
    logic inv_oe;
    logic inv_out;
    logic open_drain;
    logic pu_high;
    logic reg_out;
    pcell_dir_t dir;
  } pcell_cfg_t;

  // Delay selections, bit 0 is pin_core[0]
  typedef struct packed {
    logic [1:0] clk_en;
    logic [1:0] oreg_pin;
    logic [1:0] core_oreg;
    logic [1:0] pin_ireg;
    logic [1:0] pin_core;
  } pcell_dly_t;

  // Pin-side signals of one cell
  typedef struct packed {
    logic data;
    logic oe_n;
  } pcell_pin_t;

endpackage

// ===== hdl/pcell_delay.sv
// Selectable four-setting delay chain of the programmable pin cell
`timescale 1ns/100ps
module pcell_delay
  import pcell_pkg::*;
#(
  parameter int STAGES = PCELL_DLY_STAGES
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [1:0] i_sel,
  input wire logic i_data,
  output logic o_data
);

  logic [STAGES-1:0] stage;

  // ****************************************************************
  // Shift chain, one stage per delay level
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stage <= '0;
    end else begin
      stage <= {stage[STAGES-2:0], i_data};
    end
  end

  // Bypass or tap one of three levels
  always_comb begin
    case (i_sel)
      2'h0: o_data = i_data;
      2'h1: o_data = stage[0];
      2'h2: o_data = stage[1];
      default: o_data = stage[2];
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_first_level: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    (i_sel == 2'h1)[*2] |-> (o_data == $past(i_data))
  ) else $error("first delay level is not one cycle");

  a_third_level: assert property (
    @(posedge i_clock) disable iff (!i_resetn)
    (i_sel == 2'h3)[*4] |-> (o_data == $past(i_data, 3))
  ) else $error("third delay level is not three cycles");

endmodule

// ===== sim/pcell_board.sv
// Board-side model of the pin wire: pull-up plus an optional outside driver
`timescale 1ns/100ps
module pcell_board (
  input wire logic i_pin_out,
  input wire logic i_pin_oe_n,
  input wire logic i_drive_en,
  input wire logic i_drive_val,
  output logic o_pin
);
  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // Released and undriven line floats up through the pull-up
  always_comb begin
    if (!i_pin_oe_n) begin
      o_pin = i_pin_out;
    end else if (i_drive_en) begin
      o_pin = i_drive_val;
    end else begin
      o_pin = 1'b1;
    end
  end
endmodule

// ===== sim/programmable_io_cell_tb.sv
// Self-checking bench of the programmable pin cell
`timescale 1ns/100ps
module programmable_io_cell_tb
  import pcell_pkg::*;
;
  // ****************************************************************
  // Stimulus signals and bookkeeping
  // ****************************************************************
  typedef struct {logic pin; logic [31:0] mask; logic [31:0] val;} pcell_note_t;
  localparam logic [7:0] f_ro = 8'h01, f_pu = 8'h02, f_od = 8'h04, f_io = 8'h08;
  localparam logic [7:0] f_ioe = 8'h10, f_fb = 8'h20, f_fp = 8'h40, f_done = 8'h80;
  logic i_clock = 1'b0, i_resetn = 1'b0, i_read = 1'b0, i_write = 1'b0;
  logic [3:0] i_address = 4'h0, i_byteenable = 4'h0;
  logic [31:0] i_writedata = 32'h0, o_readdata, seen;
  logic i_core_out = 1'b0, i_core_oe = 1'b0, i_core_ce = 1'b1, i_core_aclr = 1'b0;
  logic i_local_out = 1'b0, i_local_oe = 1'b0, drive_en = 1'b0, drive_val = 1'b0;
  logic pr = 1'b0, o_waitrequest, o_core_in, o_core_reg, o_fast_dist, o_pin_out, o_pin_oe_n;
  logic pin;
  logic [31:0] seed = 32'h00016d82; // Starts at 93570
  int fails = 0, compares = 0, cycles = 0;
  pcell_note_t notes[$];
  pcell_note_t nt;

  always #25 i_clock = ~i_clock;

  pcell_top dut (.i_clock, .i_resetn, .i_address, .i_read, .i_write, .i_byteenable,
    .i_writedata, .o_readdata, .o_waitrequest, .i_core_out, .i_core_oe, .i_core_ce,
    .i_core_aclr, .i_local_out, .i_local_oe, .o_core_in, .o_core_reg, .o_fast_dist,
    .i_pin(pin), .o_pin_out, .o_pin_oe_n);

  pcell_board board (.i_pin_out(o_pin_out), .i_pin_oe_n(o_pin_oe_n), .i_drive_en(drive_en),
    .i_drive_val(drive_val), .o_pin(pin));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] cfg(input logic [1:0] d, input logic [7:0] f);
    return {22'h0, f, d};
  endfunction

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge i_clock);
    i_address <= a;
    i_write <= wr;
    i_read <= !wr;
    i_writedata <= d;
    i_byteenable <= be;
    do begin
      @(posedge i_clock);
    end while (o_waitrequest !== 1'b0);
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
    notes.push_back('{1'b0, m, v});
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic pexp(input logic [4:0] m, input logic [4:0] v);
    notes.push_back('{1'b1, {27'h0, m}, {27'h0, v}});
  endtask

  task automatic probe(input int n);
    pr <= 1'b1;
    repeat (n) @(posedge i_clock);
    pr <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic settle();
    repeat (12) @(posedge i_clock);
  endtask

  task automatic pchk(input logic [4:0] m, input logic [4:0] v);
    pexp(m, v);
    probe(1);
  endtask

  // Monitor: oldest note against read data or sampled pin outputs
  always @(posedge i_clock) begin
    if (pr || (i_read && o_waitrequest === 1'b0)) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        nt = notes.pop_front();
        seen = nt.pin ? {27'h0, o_pin_oe_n, o_pin_out, o_core_in, o_core_reg, o_fast_dist}
                      : o_readdata;
        check(seen & nt.mask, nt.val & nt.mask);
      end
    end
  end

  // Hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic v;
    logic [4:0] m;
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    // Reset state and register map
    pchk(5'h1b, 5'h10);
    rd(PCELL_OFS_CONFIG, 32'hffffffff, {22'h0, PCELL_CFG_RST});
    rd(PCELL_OFS_DELAY, 32'hffffffff, {22'h0, PCELL_DLY_RST});
    rd(PCELL_OFS_STATUS, 32'h4, 32'h0);
    d = xs();
    bus(1'b1, PCELL_OFS_DELAY, d, 4'hf);
    rd(PCELL_OFS_DELAY, 32'hffffffff, d & 32'h3ff);
    bus(1'b1, PCELL_OFS_DELAY, ~d, 4'h1);
    rd(PCELL_OFS_DELAY, 32'hffffffff, {22'h0, d[9:8], ~d[7:0]});
    bus(1'b1, PCELL_OFS_STATUS, 32'hf, 4'hf);
    bus(1'b1, 4'hc, xs(), 4'hf);
    rd(4'hc, 32'hffffffff, 32'h0);
    bus(1'b1, PCELL_OFS_DELAY, 32'h0, 4'hf);
    // Output mode, before and after configuration completes
    bus(1'b1, PCELL_OFS_CONFIG, cfg(PCELL_DIR_OUT, 8'h0), 4'hf);
    settle();
    pchk(5'h10, 5'h10);
    bus(1'b1, PCELL_OFS_CONFIG, cfg(PCELL_DIR_OUT, f_done), 4'hf);
    repeat (6) begin
      d = xs();
      i_core_out <= d[0];
      settle();
      pchk(5'h1c, {1'b0, d[0], d[0], 2'b00});
    end
    // Exact latency per delay setting on four paths
    for (int j = 0; j <= 6; j += 2) begin
      m = (j == 0) ? 5'h04 : (j == 2) ? 5'h02 : 5'h08;
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, PCELL_OFS_DELAY, 32'(k) << j, 4'hf);
        i_core_out <= 1'b0;
        settle();
        i_core_out <= 1'b1;
        repeat (k + ((j < 4) ? j / 2 + 1 : 0)) @(posedge i_clock);
        pexp(m, 5'h00);
        pexp(m, m);
        probe(2);
      end
    end
    bus(1'b1, PCELL_OFS_DELAY, 32'h0, 4'hf);
    // Inversion of routing data and enable
    bus(1'b1, PCELL_OFS_CONFIG, cfg(PCELL_DIR_OUT, f_done | f_io), 4'hf);
    settle();
    pchk(5'h08, 5'h00);
    bus(1'b1, PCELL_OFS_CONFIG, cfg(PCELL_DIR_BIDIR, f_done | f_ioe), 4'hf);
    i_core_oe <= 1'b1;
    settle();
    pchk(5'h10, 5'h10);
    i_core_oe <= 1'b0;
    settle();
    pchk(5'h10, 5'h00);
    // Input receive, bidirectional and fast bidirectional receive and drive
    for (int i = 0; i < 6; i++) begin
      v = i[0];
      bus(1'b1, PCELL_OFS_CONFIG, i < 2 ? cfg(PCELL_DIR_IN, f_done) :
          cfg(PCELL_DIR_BIDIR, f_done | (i > 3 ? f_fb : 8'h0)), 4'hf);
      i_core_oe <= (i < 2);
      drive_en <= 1'b1;
      drive_val <= v;
      settle();
      pchk(5'h16, {1'b1, 1'b0, v, v, 1'b0});
      if (i > 1) begin
        i_core_oe <= 1'b1;
        drive_en <= 1'b0;
        i_core_out <= v;
        settle();
        pchk(5'h1c, {1'b0, v, v, 2'b00});
      end
    end
    drive_en <= 1'b0;
    // Open drain never drives high
    bus(1'b1, PCELL_OFS_CONFIG, cfg(PCELL_DIR_OUT, f_done | f_od), 4'hf);
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      i_core_out <= v;
      settle();
      pchk(5'h1c, {v, 1'b0, v, 2'b00});
      rd(PCELL_OFS_STATUS, 32'h4, {29'h0, ~v, 2'b00});
    end
    // Start value, clear or preset, clock enable
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      bus(1'b1, PCELL_OFS_CONFIG, cfg(PCELL_DIR_OUT, f_done | f_ro | (v ? f_pu : 8'h0)), 4'hf);
      i_core_out <= ~v;
      settle();
      pchk(5'h0a, {1'b0, ~v, 1'b0, ~v, 1'b0});
      i_core_aclr <= 1'b1;
      settle();
      pchk(5'h0a, {1'b0, v, 1'b0, v, 1'b0});
      i_core_aclr <= 1'b0;
      i_core_ce <= 1'b0;
      settle();
      pchk(5'h08, {1'b0, v, 3'b000});
      i_core_ce <= 1'b1;
    end
    // Fast pin sourced from local routing
    bus(1'b1, PCELL_OFS_CONFIG, cfg(PCELL_DIR_BIDIR_ALT, f_done | f_fp), 4'hf);
    i_core_oe <= 1'b0;
    i_local_oe <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      v = i[0];
      i_local_out <= v;
      settle();
      pchk(5'h19, {1'b0, v, 2'b00, v});
    end
    give_verdict();
  end
endmodule
